// *** fil_map.svh ***
/*
   Register offsets, field positions, reset values and timing counts for the flash image loader.
   Assumes a 25 MHz system clock and a word-wide parallel NOR flash read asynchronously.
*/
// Notes on behaviour
// R1: After reset or reload request, configure the target with the 32-bit stream.
// R2: Two images, factory and user; the selection switch decides which loads; the code loads factory at power-up and the select button also flips it.
// R3: Load starts at power-up, on load-image button and on master-reset button.
// R4: Flash words are driven on a 32-bit data bus beside a stream clock.
// R5: Stream clock rate selectable among 25, 50 and 100 MHz; at the 25 MHz system clock all three settings give 12.5 MHz.
// R6: Valid flags each word; advance only on words the target accepted.
// R7: Once the target is in user mode, all flash outputs are released.
// R8: Flash bus is used only before target initialization; no arbitration.
// R9: Scheme codes: 000 x32 stream, 101 x16 stream, 011 serial, 111 JTAG only.
// R10: Scheme select resets to the 32-bit stream code.
// R11: Drive error, configuration-active and configuration-done lamps.
// R12: Show the selected image on a three-bit lamp output.
// R13: A changed selection loads only after a load-image button press; the code also loads it on a master-reset press or a CTRL load-bit write.
// R14: Target error stops streaming, lights error, keeps flash driven until reload.
// R15: Active lamp stays on from load start until done or error.
`ifndef FIL_MAP_SVH
`define FIL_MAP_SVH

// -----------------------------------------------------------------
// Registers
// -----------------------------------------------------------------
`define FIL_REG_CTRL 8'h00
`define FIL_REG_STATUS 8'h04
`define FIL_REG_IRQ_STAT 8'h08
`define FIL_REG_IRQ_MASK 8'h0C
`define FIL_REG_WORDS 8'h10
`define FIL_CTRL_RATE_LSB 0
`define FIL_CTRL_SCHEME_LSB 2
`define FIL_CTRL_LOAD_BIT 8
`define FIL_WORDS_RESET 26'h0001000
`define FIL_FACTORY_BASE 26'h0000000
`define FIL_USER_BASE 26'h0800000

// -----------------------------------------------------------------
// Scheme codes
// -----------------------------------------------------------------
`define FIL_SCHEME_X32 3'h0
`define FIL_SCHEME_X16 3'h5
`define FIL_SCHEME_SERIAL 3'h3
`define FIL_SCHEME_JTAG 3'h7

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define FIL_CLK_NS 40
`define FIL_RATE_SLOW_MHZ 25
`define FIL_RATE_MID_MHZ 50
`define FIL_RATE_FAST_MHZ 100
`define FIL_NCFG_LOW_NS 2000
`define FIL_NCFG_LOW_CYC ((`FIL_NCFG_LOW_NS + `FIL_CLK_NS - 1) / `FIL_CLK_NS)
`define FIL_FLASH_ACC_NS 110
`define FIL_FLASH_ACC_CYC ((`FIL_FLASH_ACC_NS + `FIL_CLK_NS - 1) / `FIL_CLK_NS)

`endif

// *** fil_pkg.sv ***
/*
   Types shared by the flash image loader.
   Assumes fil_map.svh is compiled alongside.
*/
package fil_pkg;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      FIL_IDLE = 4'h0,
      FIL_PULSE = 4'h1,
      FIL_WAIT_STATUS = 4'h2,
      FIL_READ = 4'h3,
      FIL_STREAM = 4'h4,
      FIL_WAIT_DONE = 4'h5,
      FIL_WAIT_INIT = 4'h6,
      FIL_USER = 4'h7,
      FIL_ERROR = 4'h8
   } fil_state_t;

   typedef struct packed {
      logic [25:0] addr;
      logic [1:0] ce_n;
      logic oe_n;
      logic we_n;
      logic adv_n;
      logic rst_n;
      logic clk;
   } fil_flash_t;

   typedef struct packed {
      logic error;
      logic active;
      logic done;
      logic [2:0] image;
   } fil_lamp_t;

endpackage

// *** fil_loader.sv ***
/*
   Flash image loader: reads a stored image from parallel NOR flash and streams it into the
   target device with a self-made stream clock and a valid/ready handshake.
   Assumes buttons and status pins are asynchronous, the register port is on i_clk,
   and the target samples data and valid on the rising edge of the stream clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fil_map.svh"

module fil_loader
   import fil_pkg::*;
#(
   parameter int SYS_MHZ = 25,
   parameter logic [25:0] FACTORY_BASE = `FIL_FACTORY_BASE,
   parameter logic [25:0] USER_BASE = `FIL_USER_BASE
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_irq,
   // Buttons and switch, pushbuttons low while pressed
   input wire logic i_image_select_button_n,
   input wire logic i_load_image_button_n,
   input wire logic i_master_reset_button_n,
   input wire logic i_image_select_switch,
   // Flash
   output fil_flash_t o_flash,
   output logic o_flash_oe,
   input wire logic [31:0] i_flash_data,
   input wire logic [1:0] i_flash_ready,
   // Target configuration port
   output logic [31:0] o_config_data,
   output logic o_config_stream_clock,
   output logic o_config_stream_valid,
   input wire logic i_target_accepts_word,
   output logic o_config_reset_n,
   input wire logic i_config_status_n,
   input wire logic i_config_done,
   input wire logic i_init_done,
   output logic [2:0] o_config_scheme_select,
   // Lamps
   output fil_lamp_t o_lamps
);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] pin_s1;
   logic [NSYNC-1:0] pin_s2;
   logic [2:0] btn_s3;
   logic [31:0] fdata_s1;
   logic [31:0] fdata_s2;

   assign pin_raw = {i_flash_ready, i_image_select_switch, i_master_reset_button_n,
                     i_load_image_button_n, i_image_select_button_n, i_init_done,
                     i_config_done, i_config_status_n, i_target_accepts_word};

   always_ff @(posedge i_clk) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      btn_s3 <= pin_s2[6:4];
      fdata_s1 <= i_flash_data;
      fdata_s2 <= fdata_s1;
   end

   wire ready_s = pin_s2[0];
   wire status_n_s = pin_s2[1];
   wire done_s = pin_s2[2];
   wire init_s = pin_s2[3];
   wire switch_s = pin_s2[7];
   wire sel_press = btn_s3[0] & ~pin_s2[4];
   wire load_press = btn_s3[1] & ~pin_s2[5];
   wire mrst_press = btn_s3[2] & ~pin_s2[6];

   // -----------------------------------------------------------------
   // Register decode
   // -----------------------------------------------------------------
   logic [1:0] rate;
   logic [2:0] scheme;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [25:0] words;
   fil_state_t state;
   fil_state_t next_state;
   logic sel_image;
   logic loaded_image;
   logic switch_q;
   logic power_up;

   wire wr_ctrl = i_wr && (i_addr == `FIL_REG_CTRL);
   wire wr_stat = i_wr && (i_addr == `FIL_REG_IRQ_STAT);
   wire wr_mask = i_wr && (i_addr == `FIL_REG_IRQ_MASK);
   wire wr_words = i_wr && (i_addr == `FIL_REG_WORDS);
   wire soft_load = wr_ctrl && i_wdata[`FIL_CTRL_LOAD_BIT];
   wire [31:0] status_word = {22'h000000, state == FIL_USER, o_lamps.done, o_lamps.active,
                              o_lamps.error, loaded_image, sel_image, state};
   logic [31:0] rd_mux;

   always_comb begin
      if (i_addr == `FIL_REG_CTRL) begin
         rd_mux = {27'h0000000, scheme, rate};
      end else if (i_addr == `FIL_REG_STATUS) begin
         rd_mux = status_word;
      end else if (i_addr == `FIL_REG_IRQ_STAT) begin
         rd_mux = {29'h00000000, irq_stat};
      end else if (i_addr == `FIL_REG_IRQ_MASK) begin
         rd_mux = {29'h00000000, irq_mask};
      end else if (i_addr == `FIL_REG_WORDS) begin
         rd_mux = {6'h00, words};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   // -----------------------------------------------------------------
   // Stream clock divider
   // -----------------------------------------------------------------
   // Half periods are floored to whole system cycles; a 25 MHz system
   // clock cannot reach any of the three rates and gives its own half rate.
   localparam int H0R = SYS_MHZ / (2 * `FIL_RATE_SLOW_MHZ);
   localparam int H1R = SYS_MHZ / (2 * `FIL_RATE_MID_MHZ);
   localparam int H2R = SYS_MHZ / (2 * `FIL_RATE_FAST_MHZ);
   localparam logic [7:0] HALF0 = (H0R < 1) ? 8'h01 : 8'(H0R);
   localparam logic [7:0] HALF1 = (H1R < 1) ? 8'h01 : 8'(H1R);
   localparam logic [7:0] HALF2 = (H2R < 1) ? 8'h01 : 8'(H2R);
   logic [7:0] div_cnt;
   wire [7:0] half = (rate == 2'h1) ? HALF1 : (rate == 2'h2) ? HALF2 : HALF0; // see R5
   wire tick = (div_cnt >= half - 8'h01);
   wire rise = tick & ~o_config_stream_clock;
   wire fall = tick & o_config_stream_clock;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         div_cnt <= 8'h00;
         o_config_stream_clock <= 1'b0;
      end else begin
         div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
         o_config_stream_clock <= o_config_stream_clock ^ tick; // see R4
      end
   end

   // -----------------------------------------------------------------
   // Load sequencer
   // -----------------------------------------------------------------
   localparam logic [7:0] NCFG_CYC = 8'(`FIL_NCFG_LOW_CYC);
   localparam logic [7:0] ACC_CYC = 8'(`FIL_FLASH_ACC_CYC + 2);
   logic [7:0] tmr;
   logic [25:0] faddr;
   logic [25:0] left;
   logic accepted;
   wire start = power_up | load_press | mrst_press | soft_load; // see R3, R13
   wire streaming = (state == FIL_READ) || (state == FIL_STREAM) || (state == FIL_WAIT_DONE);
   wire target_err = streaming && !status_n_s;
   wire last_word = (left == 26'h0000001);

   always_comb begin
      next_state = state;
      if (start) begin
         next_state = FIL_PULSE; // see R1
      end else begin
         case (state)
            FIL_PULSE: begin
               if (tmr == 8'h00) begin
                  next_state = FIL_WAIT_STATUS;
               end
            end
            FIL_WAIT_STATUS: begin
               if (status_n_s) begin
                  next_state = FIL_READ;
               end
            end
            FIL_READ: begin
               if (target_err) begin
                  next_state = FIL_ERROR;
               end else if (tmr == 8'h00) begin
                  next_state = FIL_STREAM;
               end
            end
            FIL_STREAM: begin
               if (target_err) begin
                  next_state = FIL_ERROR; // see R14
               end else if (fall && accepted) begin
                  next_state = last_word ? FIL_WAIT_DONE : FIL_READ; // see R6
               end
            end
            FIL_WAIT_DONE: begin
               if (target_err) begin
                  next_state = FIL_ERROR;
               end else if (done_s) begin
                  next_state = FIL_WAIT_INIT;
               end
            end
            FIL_WAIT_INIT: begin
               if (init_s) begin
                  next_state = FIL_USER; // see R7
               end
            end
            default: begin
               next_state = state;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= FIL_IDLE;
         power_up <= 1'b1;
         tmr <= 8'h00;
         faddr <= 26'h0000000;
         left <= 26'h0000000;
         accepted <= 1'b0;
         loaded_image <= 1'b0;
         o_config_stream_valid <= 1'b0;
         o_config_data <= 32'h00000000;
         o_config_reset_n <= 1'b1;
      end else begin
         state <= next_state;
         power_up <= 1'b0;
         tmr <= (tmr != 8'h00) ? tmr - 8'h01 : 8'h00;
         o_config_reset_n <= (next_state != FIL_PULSE);
         if (start) begin
            tmr <= NCFG_CYC;
            loaded_image <= sel_image; // see R2
            faddr <= sel_image ? USER_BASE : FACTORY_BASE;
            left <= words;
            accepted <= 1'b0;
            o_config_stream_valid <= 1'b0;
         end else if (next_state == FIL_ERROR) begin
            o_config_stream_valid <= 1'b0; // see R14
         end else if (state == FIL_WAIT_STATUS && next_state == FIL_READ) begin
            tmr <= ACC_CYC;
         end else if (state == FIL_READ && next_state == FIL_STREAM) begin
            o_config_data <= fdata_s2; // see R4
            o_config_stream_valid <= 1'b1;
         end else if (state == FIL_STREAM) begin
            if (rise && ready_s) begin
               accepted <= 1'b1;
            end
            if (fall && accepted) begin
               accepted <= 1'b0;
               o_config_stream_valid <= 1'b0; // see R6
               faddr <= faddr + 26'h0000001;
               left <= left - 26'h0000001;
               tmr <= ACC_CYC; // Next word's flash access time starts here
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Flash pins
   // -----------------------------------------------------------------
   // No arbitration: the bus is released once the target runs, until the next load request.
   wire reading = (state == FIL_READ);
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_flash <= '{addr: 26'h0000000, ce_n: 2'h3, oe_n: 1'b1, we_n: 1'b1,
                      adv_n: 1'b1, rst_n: 1'b1, clk: 1'b0};
         o_flash_oe <= 1'b1;
      end else begin
         o_flash.addr <= faddr;
         o_flash.ce_n <= reading ? 2'h0 : 2'h3;
         o_flash.oe_n <= ~reading;
         o_flash.we_n <= 1'b1;
         o_flash.adv_n <= ~reading;
         o_flash.rst_n <= 1'b1;
         o_flash.clk <= 1'b0;
         o_flash_oe <= (next_state != FIL_USER); // see R7, R8
      end
   end

   // -----------------------------------------------------------------
   // Selection, scheme and lamps
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sel_image <= 1'b0;
         switch_q <= 1'b0;
         o_lamps <= '{error: 1'b0, active: 1'b0, done: 1'b0, image: 3'h0};
         o_config_scheme_select <= `FIL_SCHEME_X32; // see R10
      end else begin
         switch_q <= switch_s;
         if (switch_s != switch_q) begin
            sel_image <= switch_s; // see R2
         end else if (sel_press) begin
            sel_image <= ~sel_image;
         end
         o_lamps.image <= {sel_image != loaded_image, sel_image, ~sel_image}; // see R12
         o_lamps.error <= (next_state == FIL_ERROR); // see R11
         o_lamps.active <= streaming || (next_state == FIL_PULSE) ||
                           (next_state == FIL_WAIT_STATUS) || (next_state == FIL_READ); // see R15
         o_lamps.done <= done_s && !start && (state != FIL_ERROR);
         o_config_scheme_select <= scheme; // see R9
      end
   end

   // -----------------------------------------------------------------
   // Software registers and interrupt
   // -----------------------------------------------------------------
   // Events: 0 load streamed and done, 1 target error, 2 flash released.
   wire [2:0] ev = {state != FIL_USER && next_state == FIL_USER,
                    state != FIL_ERROR && next_state == FIL_ERROR,
                    state == FIL_WAIT_DONE && next_state == FIL_WAIT_INIT};
   wire [2:0] clr = wr_stat ? i_wdata[2:0] : 3'h0;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rate <= 2'h0;
         scheme <= `FIL_SCHEME_X32;
         words <= `FIL_WORDS_RESET;
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         o_irq <= 1'b0;
         o_rdata <= 32'h00000000;
      end else begin
         if (wr_ctrl) begin
            rate <= i_wdata[`FIL_CTRL_RATE_LSB +: 2];
            scheme <= i_wdata[`FIL_CTRL_SCHEME_LSB +: 3];
         end
         if (wr_words) begin
            words <= i_wdata[25:0];
         end
         if (wr_mask) begin
            irq_mask <= i_wdata[2:0];
         end
         irq_stat <= (irq_stat & ~clr) | ev;
         o_irq <= |(irq_stat & irq_mask);
         o_rdata <= i_rd ? rd_mux : 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// *** fil_loader_monitor.sv ***
/*
   Concurrent checks on the flash image loader ports.
   Assumes a bind into fil_loader, so every input is one of its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fil_map.svh"
module fil_loader_monitor
   import fil_pkg::*;
(
   // Loader inputs
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_load_image_button_n,
   input wire logic i_master_reset_button_n,
   input wire logic i_image_select_switch,
   input wire logic i_config_done,
   input wire logic i_init_done,
   // Loader outputs
   input wire fil_flash_t o_flash,
   input wire logic o_flash_oe,
   input wire logic [31:0] o_config_data,
   input wire logic o_config_stream_valid,
   input wire logic o_config_reset_n,
   input wire logic [2:0] o_config_scheme_select,
   input wire fil_lamp_t o_lamps
);
   localparam int NCFG = `FIL_NCFG_LOW_CYC;
   int low_cnt;
   int since_start;
   wire ctrl_wr = i_wr && i_addr == `FIL_REG_CTRL;
   wire start_req = i_rst || !i_load_image_button_n || !i_master_reset_button_n ||
      (ctrl_wr && i_wdata[`FIL_CTRL_LOAD_BIT]);
   // Counters saturate so a long idle spell cannot wrap them
   always_ff @(posedge i_clk) begin
      if (o_config_reset_n) low_cnt <= 0;
      else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
      if (start_req) since_start <= 0;
      else if (since_start < 1000) since_start <= since_start + 1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_SCHEME_RESET: assert property (
      $fell(i_rst) |-> o_config_scheme_select == 3'h0) else $error("scheme reset value");
   AST_SCHEME_WRITE: assert property (
      ctrl_wr ##1 !ctrl_wr |=> o_config_scheme_select == $past(i_wdata[4:2], 2))
      else $error("scheme select not copied");
   AST_FLASH_OWNED: assert property (
      o_flash.ce_n != 2'h3 |-> o_flash_oe) else $error("flash read while released");
   AST_RELEASE_USER: assert property (
      $fell(o_flash_oe) |-> i_config_done && i_init_done) else $error("early release");
   AST_WORD_HOLD: assert property (
      $past(o_config_stream_valid) && o_config_stream_valid |-> $stable(o_config_data))
      else $error("word changed while offered");
   AST_ERROR_HOLD: assert property (
      $rose(o_lamps.error) |=> (o_flash_oe && !o_config_stream_valid) [*4])
      else $error("error did not stop stream");
   AST_ACTIVE_OFF: assert property (
      o_lamps.error && $past(o_lamps.error) |-> !o_lamps.active) else $error("active on");
   AST_ACTIVE_STREAM: assert property (
      o_config_stream_valid |-> o_lamps.active) else $error("active off in stream");
   AST_PULSE_LEN: assert property (
      $rose(o_config_reset_n) |-> low_cnt >= NCFG) else $error("reset pulse short");
   AST_LOAD_CAUSE: assert property (
      $fell(o_config_reset_n) |-> since_start < 12) else $error("load without request");
   AST_IMAGE_LAMP: assert property (
      $changed(i_image_select_switch) |-> ##[3:8] (o_lamps.image[1] == i_image_select_switch
      && o_lamps.image[0] != i_image_select_switch)) else $error("image lamps wrong");
   COV_RELEASE: cover property ($fell(o_flash_oe));
   COV_ERROR: cover property ($rose(o_lamps.error));
   COV_WORD: cover property ($fell(o_config_stream_valid));
endmodule
`default_nettype wire

// *** fil_target_model.sv ***
/*
   Far-side model: target configuration port and shared flash.
   Assumes the loader's outputs change on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fil_target_model (
   // Loader side
   input wire logic i_clk,
   input wire logic [25:0] i_addr,
   input wire logic i_read,
   input wire logic [31:0] i_data,
   input wire logic i_valid,
   input wire logic i_reset_n,
   output logic [31:0] o_flash_data,
   output logic o_ready,
   output logic o_status_n,
   output logic o_done,
   output logic o_init,
   // Bench control
   input wire logic [25:0] i_words,
   input wire logic i_slow,
   input wire logic i_fail,
   output int o_count,
   output logic [31:0] o_first,
   output logic [31:0] o_last
);
   logic [31:0] last;
   logic [31:0] dq;
   logic vq;
   int age;
   int init_cnt;
   // Off the bus the data toggles, so a stale sample never matches
   assign o_flash_data = i_read ? {6'h2A, i_addr} : ~last;
   assign o_ready = age > (i_slow ? 40 : 2);
   assign o_status_n = i_reset_n && !(i_fail && o_count > 0);
   assign o_done = i_reset_n && o_count >= int'(i_words);
   assign o_init = init_cnt >= 8;
   always_ff @(posedge i_clk) begin
      last <= o_flash_data;
      vq <= i_valid;
      dq <= i_data;
      if (!i_reset_n) begin
         age <= 0;
         o_count <= 0;
         init_cnt <= 0;
      end else begin
         age <= age + 1;
         // A word counts only if it leaves while ready was up
         if (vq && !i_valid && o_status_n && o_ready) begin
            if (o_count == 0) o_first <= dq;
            o_last <= dq;
            o_count <= o_count + 1;
         end
         if (o_done) init_cnt <= init_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// *** fil_loader_tb_top.sv ***
/*
   Bench for the flash image loader with the target and flash model beside it.
   Assumes package, header, loader, model and monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module fil_loader_tb_top;
   import fil_pkg::*;
   localparam logic [25:0] USER = 26'h0800000;
   logic i_clk, i_rst, i_wr, i_rd, i_image_select_switch, slow, fail, i_target_accepts_word;
   logic i_config_status_n, i_config_done, i_init_done, o_irq, o_flash_oe;
   logic o_config_stream_clock, o_config_stream_valid, o_config_reset_n;
   logic [2:0] btn_n, o_config_scheme_select;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, i_flash_data, o_config_data, first, last, rd;
   logic [2:0] codes [4] = '{3'h5, 3'h3, 3'h7, 3'h0};
   fil_flash_t o_flash;
   fil_lamp_t o_lamps;
   int count, k, miscompares = 0, num_checks = 0;
   fil_loader #(.FACTORY_BASE(26'h0), .USER_BASE(USER)) u_fil_loader (.i_clk, .i_rst,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_image_select_button_n(btn_n[1]),
      .i_load_image_button_n(btn_n[0]), .i_master_reset_button_n(btn_n[2]),
      .i_image_select_switch, .o_flash, .o_flash_oe, .i_flash_data, .i_flash_ready(2'h3),
      .o_config_data, .o_config_stream_clock, .o_config_stream_valid, .i_target_accepts_word,
      .o_config_reset_n, .i_config_status_n, .i_config_done, .i_init_done,
      .o_config_scheme_select, .o_lamps);
   fil_target_model u_fil_target_model (.i_clk, .i_addr(o_flash.addr),
      .i_read(o_flash_oe && o_flash.ce_n != 2'h3 && !o_flash.oe_n), .i_data(o_config_data),
      .i_valid(o_config_stream_valid), .i_reset_n(o_config_reset_n),
      .o_flash_data(i_flash_data), .o_ready(i_target_accepts_word), .o_first(first),
      .o_status_n(i_config_status_n), .o_done(i_config_done), .o_init(i_init_done),
      .i_words(26'h4), .i_slow(slow), .i_fail(fail), .o_count(count), .o_last(last));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      rd = o_rdata;
   endtask
   task automatic press(input int b);
      @(posedge i_clk);
      btn_n[b] <= 1'b0;
      repeat (4) @(posedge i_clk);
      btn_n[b] <= 1'b1;
   endtask
   task automatic wait_user();
      for (k = 0; k < 20 && o_flash_oe !== 1'b1; k++) @(negedge i_clk);
      for (k = 0; k < 4000 && o_flash_oe !== 1'b0; k++) @(negedge i_clk);
      chk("flash released", 32'h0, 32'(o_flash_oe));
   endtask
   task automatic t_reset();
      @(negedge i_clk);
      chk("scheme", 32'h0, 32'(o_config_scheme_select));
      chk("lamps", 32'h0, 32'(o_lamps));
      @(posedge i_clk);
      i_rst <= 1'b0;
      for (k = 0; k < 10 && o_config_reset_n !== 1'b0; k++) @(negedge i_clk);
      chk("power-up pulse", 32'h0, 32'(o_config_reset_n));
      chk("active lamp", 32'h1, 32'(o_lamps.active));
   endtask
   task automatic t_regs();
      wr(8'h10, 32'h4);
      rdr(8'h10);
      chk("word count", 32'h4, rd);
      rdr(8'h20);
      chk("unmapped", 32'h0, rd);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, 32'({codes[i], 2'(i % 3)}));
         repeat (3) @(negedge i_clk);
         chk("scheme", 32'(codes[i]), 32'(o_config_scheme_select));
         rdr(8'h00);
         chk("control", 32'({codes[i], 2'(i % 3)}), rd);
      end
      @(negedge i_clk);
      rd = 32'(o_config_stream_clock);
      @(negedge i_clk);
      chk("stream clock", rd ^ 32'h1, 32'(o_config_stream_clock));
   endtask
   task automatic t_factory();
      wr(8'h00, 32'h100);
      wait_user();
      chk("words", 32'h4, 32'(count));
      chk("first word", {6'h2A, 26'h0}, first);
      chk("last word", {6'h2A, 26'h3}, last);
      chk("lamps", 32'h9, 32'(o_lamps));
      chk("masked irq", 32'h0, 32'(o_irq));
      rdr(8'h04);
      chk("status", 32'h307, rd);
      rdr(8'h08);
      chk("irq status", 32'h5, rd);
      wr(8'h0C, 32'h1);
      repeat (3) @(negedge i_clk);
      chk("irq", 32'h1, 32'(o_irq));
      wr(8'h08, 32'h7);
      repeat (3) @(negedge i_clk);
      chk("irq cleared", 32'h0, 32'(o_irq));
   endtask
   task automatic t_user();
      @(posedge i_clk);
      i_image_select_switch <= 1'b1;
      repeat (10) @(negedge i_clk);
      chk("image lamps", 32'h6, 32'(o_lamps.image));
      chk("no reload", 32'h0, 32'(o_flash_oe));
      slow = 1'b1;
      press(0);
      wait_user();
      chk("first word", {6'h2A, USER}, first);
      chk("words", 32'h4, 32'(count));
      chk("image lamps", 32'h2, 32'(o_lamps.image));
      slow = 1'b0;
   endtask
   task automatic t_error();
      fail = 1'b1;
      press(2);
      for (k = 0; k < 4000 && o_lamps.error !== 1'b1; k++) @(negedge i_clk);
      repeat (20) @(negedge i_clk);
      chk("status lamps", 32'h4, 32'(o_lamps[5:3]));
      chk("flash drive", 32'h1, 32'(o_flash_oe));
      chk("valid", 32'h0, 32'(o_config_stream_valid));
      fail = 1'b0;
      press(1);
      repeat (10) @(negedge i_clk);
      chk("image lamps", 32'h5, 32'(o_lamps.image));
      chk("error kept", 32'h1, 32'(o_lamps.error));
      wr(8'h00, 32'h100);
      wait_user();
      chk("first word", {6'h2A, 26'h0}, first);
      chk("lamps", 32'h9, 32'(o_lamps));
   endtask
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      stop_test();
   end
   initial begin
      i_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      btn_n = 3'h7;
      i_image_select_switch = 1'b0;
      slow = 1'b0;
      fail = 1'b0;
      repeat (5) @(posedge i_clk);
      t_reset();
      t_regs();
      t_factory();
      t_user();
      t_error();
      stop_test();
   end
endmodule
bind fil_loader fil_loader_monitor u_fil_loader_monitor (.i_clk, .i_rst, .i_addr, .i_wdata,
   .i_wr, .i_load_image_button_n, .i_master_reset_button_n, .i_image_select_switch,
   .i_config_done, .i_init_done, .o_flash, .o_flash_oe, .o_config_data,
   .o_config_stream_valid, .o_config_reset_n, .o_config_scheme_select, .o_lamps);
`default_nettype wire
